// ---- core/sfi_consts.svh ----
`ifndef SFI_CONSTS_SVH
`define SFI_CONSTS_SVH

// ****************************************
// Instruction codes
// ****************************************
`define SFI_OP_EXT0_REQ 10'h038
`define SFI_OP_EXT1_REQ 10'h039
`define SFI_OP_CONV_DONE 10'h287
`define SFI_OP_EXT0_PIN 10'h03a
`define SFI_OP_EXT1_PIN 10'h03b
`define SFI_OP_POWER_DOWN 10'h003

// ****************************************
// Register offsets
// ****************************************
`define SFI_ADDR_IRQ_CTRL_A 8'h00
`define SFI_ADDR_IRQ_CTRL_B 8'h04
`define SFI_ADDR_EDGE_CTRL_A 8'h08
`define SFI_ADDR_EDGE_CTRL_B 8'h0c
`define SFI_ADDR_FLAGS 8'h10
`define SFI_ADDR_STATUS 8'h14
`define SFI_ADDR_MASK 8'h18

// ****************************************
// Field positions
// ****************************************
`define SFI_EXT0_EN_BIT 0
`define SFI_EXT1_EN_BIT 1
`define SFI_CONV_EN_BIT 2
`define SFI_POLARITY_BIT 2
`define SFI_EV_SKIP 0
`define SFI_EV_CLEAR 1
`define SFI_EV_NOP 2
`define SFI_EV_DISCARD 3

// ****************************************
// Reset values and widths
// ****************************************
`define SFI_REG_W 4
`define SFI_CTRL_RESET 4'h0
`define SFI_RESP_OKAY 2'h0
`define SFI_RESP_SLVERR 2'h2

`endif

// ---- core/sfi_pkg.sv ----
package sfi_pkg;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_EXT0_REQ,
		KIND_EXT1_REQ,
		KIND_CONV_DONE,
		KIND_EXT0_PIN,
		KIND_EXT1_PIN,
		KIND_POWER_DOWN
	} sfi_kind_t;

	typedef struct packed {
		logic valid;
		logic [9:0] word;
	} sfi_instr_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
	} sfi_addr_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
		logic [3:0] strb;
	} sfi_wdata_t;

endpackage

// ---- core/sfi_sync.sv ----
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module sfi_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_q <= '0;
			syncOut <= '0;
		end else begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end

endmodule // sfi_sync

// ---- core/sfi_flag.sv ----
// ****************************************
// Sticky flags, set wins over clear
// ****************************************
module sfi_flag #(
	parameter int WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] setIn,
	input wire logic [WIDTH-1:0] clearIn,
	output logic [WIDTH-1:0] flag_q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					flag_q[i] <= 1'b0;
				end else if (setIn[i]) begin
					flag_q[i] <= 1'b1;
				end else if (clearIn[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule // sfi_flag

// ---- core/sfi_skip_unit.sv ----
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`include "sfi_consts.svh"

module sfi_skip_unit (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire sfi_pkg::sfi_instr_t instrIn,
	input wire logic ext0RequestSet,
	input wire logic ext1RequestSet,
	input wire logic conversionDoneSet,
	input wire logic powerDownFlag,
	input wire logic extIrqPinZero,
	input wire logic extIrqPinOne,
	output logic skipNext_q,
	output logic discardNext_q,
	output logic [2:0] requestFlags_q,
	output logic irq_q
);

	// ****************************************
	// Decoding
	// ****************************************
	function automatic sfi_pkg::sfi_kind_t decodeKind(input logic [9:0] word);
		case (word)
			`SFI_OP_EXT0_REQ: decodeKind = sfi_pkg::KIND_EXT0_REQ;
			`SFI_OP_EXT1_REQ: decodeKind = sfi_pkg::KIND_EXT1_REQ;
			`SFI_OP_CONV_DONE: decodeKind = sfi_pkg::KIND_CONV_DONE;
			`SFI_OP_EXT0_PIN: decodeKind = sfi_pkg::KIND_EXT0_PIN;
			`SFI_OP_EXT1_PIN: decodeKind = sfi_pkg::KIND_EXT1_PIN;
			`SFI_OP_POWER_DOWN: decodeKind = sfi_pkg::KIND_POWER_DOWN;
			default: decodeKind = sfi_pkg::KIND_NONE;
		endcase
	endfunction

	function automatic logic [31:0] widen(input logic [3:0] value);
		widen = {28'h0000000, value};
	endfunction

	logic [3:0] irqCtrlA_q;
	logic [3:0] irqCtrlB_q;
	logic [3:0] edgeCtrlA_q;
	logic [3:0] edgeCtrlB_q;
	logic [3:0] mask_q;
	logic [3:0] status;
	logic [2:0] reqFlags;
	logic [1:0] pinSync;
	logic skipPending_q;

	sfi_sync #(.WIDTH(2)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.asyncIn({extIrqPinOne, extIrqPinZero}),
		.syncOut(pinSync)
	);

	wire decValid = instrIn.valid & ~skipPending_q;
	wire sfi_pkg::sfi_kind_t kind = decodeKind(instrIn.word);
	wire isExt0 = decValid && kind == sfi_pkg::KIND_EXT0_REQ;
	wire isExt1 = decValid && kind == sfi_pkg::KIND_EXT1_REQ;
	wire isConv = decValid && kind == sfi_pkg::KIND_CONV_DONE;
	wire isPin0 = decValid && kind == sfi_pkg::KIND_EXT0_PIN;
	wire isPin1 = decValid && kind == sfi_pkg::KIND_EXT1_PIN;
	wire isPd = decValid && kind == sfi_pkg::KIND_POWER_DOWN;
	wire en0 = irqCtrlA_q[`SFI_EXT0_EN_BIT];
	wire en1 = irqCtrlA_q[`SFI_EXT1_EN_BIT];
	wire enC = irqCtrlB_q[`SFI_CONV_EN_BIT];
	wire pol0 = edgeCtrlA_q[`SFI_POLARITY_BIT];
	wire pol1 = edgeCtrlB_q[`SFI_POLARITY_BIT];

	// ****************************************
	// Skip conditions
	// ****************************************
	wire takeExt0 = isExt0 & ~en0 & reqFlags[0];
	wire takeExt1 = isExt1 & ~en1 & reqFlags[1];
	wire takeConv = isConv & ~enC & reqFlags[2];
	wire takePin0 = isPin0 & (pinSync[0] == pol0);
	wire takePin1 = isPin1 & (pinSync[1] == pol1);
	wire takePd = isPd & powerDownFlag;
	wire takeSkip = takeExt0 | takeExt1 | takeConv | takePin0 | takePin1 | takePd;
	wire [2:0] reqClear = {takeConv, takeExt1, takeExt0};
	wire nopDone = (isExt0 & en0) | (isExt1 & en1) | (isConv & enC);
	wire discardNow = instrIn.valid & skipPending_q;

	sfi_flag #(.WIDTH(3)) u_req (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.setIn({conversionDoneSet, ext1RequestSet, ext0RequestSet}),
		.clearIn(reqClear),
		.flag_q(reqFlags)
	);

	// ****************************************
	// Skip sequencing
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			skipPending_q <= 1'b0;
			skipNext_q <= 1'b0;
			discardNext_q <= 1'b0;
			requestFlags_q <= 3'h0;
		end else begin
			skipPending_q <= takeSkip | (skipPending_q & ~instrIn.valid);
			skipNext_q <= takeSkip;
			discardNext_q <= discardNow;
			requestFlags_q <= reqFlags;
		end
	end

	// ****************************************
	// Interrupt status
	// ****************************************
	logic [3:0] events;
	logic [3:0] statusClear;
	assign events[`SFI_EV_SKIP] = takeSkip;
	assign events[`SFI_EV_CLEAR] = |reqClear;
	assign events[`SFI_EV_NOP] = nopDone;
	assign events[`SFI_EV_DISCARD] = discardNow;

	sfi_flag #(.WIDTH(4)) u_status (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.setIn(events),
		.clearIn(statusClear),
		.flag_q(status)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status & mask_q);
		end
	end

	// ****************************************
	// Register bus, write side
	// ****************************************
	sfi_pkg::sfi_addr_t awHeld_q;
	sfi_pkg::sfi_wdata_t wHeld_q;
	wire doWrite = awHeld_q.valid & wHeld_q.valid & ~s_axi_bvalid;
	wire wrLane = wHeld_q.strb[0];
	wire [3:0] wrVal = wHeld_q.data[3:0];
	wire wrCtrlA = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_IRQ_CTRL_A;
	wire wrCtrlB = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_IRQ_CTRL_B;
	wire wrEdgeA = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_EDGE_CTRL_A;
	wire wrEdgeB = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_EDGE_CTRL_B;
	wire wrStatus = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_STATUS;
	wire wrMask = doWrite && wrLane && awHeld_q.addr == `SFI_ADDR_MASK;
	wire wrKnown = wrCtrlA | wrCtrlB | wrEdgeA | wrEdgeB | wrStatus | wrMask
		| (awHeld_q.addr == `SFI_ADDR_FLAGS) | ~wrLane;
	assign statusClear = wrStatus ? wrVal : 4'h0;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld_q <= '0;
			wHeld_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SFI_RESP_OKAY;
		end else begin
			s_axi_awready <= ~awHeld_q.valid & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHeld_q.valid & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld_q <= '{valid: 1'b1, addr: s_axi_awaddr};
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld_q <= '{valid: 1'b1, data: s_axi_wdata, strb: s_axi_wstrb};
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrKnown ? `SFI_RESP_OKAY : `SFI_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_q.valid <= 1'b0;
				wHeld_q.valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqCtrlA_q <= `SFI_CTRL_RESET;
			irqCtrlB_q <= `SFI_CTRL_RESET;
			edgeCtrlA_q <= `SFI_CTRL_RESET;
			edgeCtrlB_q <= `SFI_CTRL_RESET;
			mask_q <= `SFI_CTRL_RESET;
		end else begin
			if (wrCtrlA) irqCtrlA_q <= wrVal;
			if (wrCtrlB) irqCtrlB_q <= wrVal;
			if (wrEdgeA) edgeCtrlA_q <= wrVal;
			if (wrEdgeB) edgeCtrlB_q <= wrVal;
			if (wrMask) mask_q <= wrVal;
		end
	end

	// ****************************************
	// Register bus, read side
	// ****************************************
	logic [7:0] rdAddr_q;
	logic rdBusy_q;
	wire [3:0] flagView = {powerDownFlag, reqFlags};
	wire [31:0] rdMux =
		(rdAddr_q == `SFI_ADDR_IRQ_CTRL_A) ? widen(irqCtrlA_q) :
		(rdAddr_q == `SFI_ADDR_IRQ_CTRL_B) ? widen(irqCtrlB_q) :
		(rdAddr_q == `SFI_ADDR_EDGE_CTRL_A) ? widen(edgeCtrlA_q) :
		(rdAddr_q == `SFI_ADDR_EDGE_CTRL_B) ? widen(edgeCtrlB_q) :
		(rdAddr_q == `SFI_ADDR_FLAGS) ? widen(flagView) :
		(rdAddr_q == `SFI_ADDR_STATUS) ? widen(status) :
		(rdAddr_q == `SFI_ADDR_MASK) ? widen(mask_q) : 32'h00000000;
	wire rdKnown = rdAddr_q <= `SFI_ADDR_MASK && rdAddr_q[1:0] == 2'h0;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdAddr_q <= 8'h00;
			rdBusy_q <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SFI_RESP_OKAY;
		end else begin
			s_axi_arready <= ~rdBusy_q & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				rdAddr_q <= s_axi_araddr;
				rdBusy_q <= 1'b1;
			end else if (rdBusy_q & ~s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdKnown ? `SFI_RESP_OKAY : `SFI_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				rdBusy_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence ext0Armed;
		isExt0 && !en0 && reqFlags[0];
	endsequence

	sequence skipThenClear(int idx);
		skipNext_q && !reqFlags[idx];
	endsequence

	ext0_skip_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(ext0Armed and !ext0RequestSet) |=> skipThenClear(0))
		else $error("ext0 request skip did not skip and clear");

	ext0_nop_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isExt0 && en0 && reqFlags[0] |=> !skipNext_q && reqFlags[0])
		else $error("disabled ext0 skip acted");

	ext1_skip_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isExt1 && !en1 && reqFlags[1] && !ext1RequestSet |=> skipThenClear(1))
		else $error("ext1 request skip did not skip and clear");

	conv_skip_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isConv && !enC && reqFlags[2] && !conversionDoneSet |=> skipThenClear(2))
		else $error("conversion skip did not skip and clear");

	conv_nop_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isConv && enC |=> !skipNext_q && ($stable(reqFlags[2]) || $past(conversionDoneSet)))
		else $error("disabled conversion skip acted");

	pin0_level_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isPin0 |=> skipNext_q == ($past(pinSync[0]) == $past(pol0)))
		else $error("ext0 pin skip wrong");

	pin1_level_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isPin1 |=> skipNext_q == ($past(pinSync[1]) == $past(pol1)))
		else $error("ext1 pin skip wrong");

	power_down_skip_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isPd |=> skipNext_q == $past(powerDownFlag))
		else $error("power-down skip wrong");

	power_down_keep_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isPd |=> reqFlags == $past(reqFlags) || $past(|{conversionDoneSet, ext1RequestSet,
			ext0RequestSet}))
		else $error("power-down skip touched a flag");

	ext1_nop_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		isExt1 && en1 && reqFlags[1] |=> !skipNext_q && reqFlags[1])
		else $error("disabled ext1 skip acted");

	skip_discard_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		skipNext_q && instrIn.valid |=> discardNext_q && !skipNext_q)
		else $error("instruction after skip not discarded");

	skip_one_cycle_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		skipNext_q |=> !skipNext_q)
		else $error("skip pulse too long");

endmodule // sfi_skip_unit

// ---- tb/skip_on_flag_instructions_tb_top.sv ----
`include "sfi_consts.svh"
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end

module skip_on_flag_instructions_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, sys_rst;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
	logic [3:0] s_axi_wstrb, ctrlA, ctrlB, edgeA, edgeB, maskM, statusM;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	sfi_pkg::sfi_instr_t instrIn;
	logic ext0RequestSet, ext1RequestSet, conversionDoneSet, powerDownFlag;
	logic extIrqPinZero, extIrqPinOne, skipNext_q, discardNext_q, irq_q;
	logic [2:0] requestFlags_q, flagsM, expReq, clr;
	logic pendM, expSkip, expDisc, sk, dc, nop, s;
	logic [9:0] ops [7];
	int failures, samplesChecked, seed, i, k, n;

	sfi_skip_unit i_sfi_skip_unit (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .instrIn(instrIn),
		.ext0RequestSet(ext0RequestSet), .ext1RequestSet(ext1RequestSet),
		.conversionDoneSet(conversionDoneSet), .powerDownFlag(powerDownFlag),
		.extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne), .skipNext_q(skipNext_q),
		.discardNext_q(discardNext_q), .requestFlags_q(requestFlags_q), .irq_q(irq_q));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Reference model
	// ****************************************
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{flagsM, statusM, pendM, expReq, expSkip, expDisc} = '0;
		end else begin
			expReq = flagsM;
			{sk, dc, nop, clr} = '0;
			if (instrIn.valid === 1'b1) begin
				if (pendM) dc = 1'b1;
				else case (instrIn.word)
					`SFI_OP_EXT0_REQ: if (ctrlA[0]) nop = 1'b1; else clr[0] = flagsM[0];
					`SFI_OP_EXT1_REQ: if (ctrlA[1]) nop = 1'b1; else clr[1] = flagsM[1];
					`SFI_OP_CONV_DONE: if (ctrlB[2]) nop = 1'b1; else clr[2] = flagsM[2];
					`SFI_OP_EXT0_PIN: sk = (extIrqPinZero == edgeA[2]);
					`SFI_OP_EXT1_PIN: sk = (extIrqPinOne == edgeB[2]);
					`SFI_OP_POWER_DOWN: sk = powerDownFlag;
					default: ;
				endcase
				sk = sk | (|clr);
				pendM = sk;
			end
			flagsM = (flagsM & ~clr) | {conversionDoneSet, ext1RequestSet, ext0RequestSet};
			statusM = statusM | {dc, |clr, nop, sk};
			expSkip = sk;
			expDisc = dc;
		end
	end

	always @(negedge sys_clk) begin
		if (!sys_rst) begin
			`CHK("skipNext", expSkip, skipNext_q)
			`CHK("discardNext", expDisc, discardNext_q)
			`CHK("requestFlags", expReq, requestFlags_q)
		end
	end

	// ****************************************
	// Drivers
	// ****************************************
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		{aw, w, b} = '0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int j = 0; j < 40 && !b; j++) begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				b = 1'b1;
				s_axi_bready <= 1'b0;
				`CHK("bresp", er, s_axi_bresp)
			end
		end
		if (!b) begin
			failures++;
			finish_test();
		end
		case (a)
			`SFI_ADDR_IRQ_CTRL_A: ctrlA = d[3:0];
			`SFI_ADDR_IRQ_CTRL_B: ctrlB = d[3:0];
			`SFI_ADDR_EDGE_CTRL_A: edgeA = d[3:0];
			`SFI_ADDR_EDGE_CTRL_B: edgeB = d[3:0];
			`SFI_ADDR_MASK: maskM = d[3:0];
			`SFI_ADDR_STATUS: statusM = statusM & ~d[3:0];
			default: ;
		endcase
		@(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic r;
		r = 1'b0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (int j = 0; j < 40 && !r; j++) begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				r = 1'b1;
				s_axi_rready <= 1'b0;
				`CHK("rdata", e, s_axi_rdata)
				`CHK("rresp", er, s_axi_rresp)
			end
		end
		if (!r) begin
			failures++;
			finish_test();
		end
		@(posedge sys_clk);
	endtask

	task automatic idle(input int c);
		instrIn <= '0;
		repeat (c) @(posedge sys_clk);
	endtask

	task automatic instr(input logic [9:0] w);
		instrIn <= '{valid: 1'b1, word: w};
		@(posedge sys_clk);
	endtask

	task automatic instr1(input logic [9:0] w, output logic sv);
		instr(w);
		instrIn <= '0;
		@(negedge sys_clk);
		sv = skipNext_q;
		@(posedge sys_clk);
	endtask

	task automatic pulse(input logic [2:0] b);
		{conversionDoneSet, ext1RequestSet, ext0RequestSet} <= b;
		@(posedge sys_clk);
		{conversionDoneSet, ext1RequestSet, ext0RequestSet} <= 3'h0;
		@(posedge sys_clk);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{failures, samplesChecked} = '0;
		seed = 32'hbac6;
		ops = '{`SFI_OP_EXT0_REQ, `SFI_OP_EXT1_REQ, `SFI_OP_CONV_DONE, `SFI_OP_EXT0_PIN,
			`SFI_OP_EXT1_PIN, `SFI_OP_POWER_DOWN, 10'h000};
		{ctrlA, ctrlB, edgeA, edgeB, maskM} = '0;
		sys_rst = 1'b1;
		instrIn = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{ext0RequestSet, ext1RequestSet, conversionDoneSet, powerDownFlag} = '0;
		{extIrqPinZero, extIrqPinOne} = '0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 8; i++) rd_chk(8'(i * 4), 32'h0, (i == 7) ? 2'h2 : 2'h0);
		axi_write(`SFI_ADDR_FLAGS, 32'hf, 2'h0);
		rd_chk(`SFI_ADDR_FLAGS, 32'h0, 2'h0);
		for (k = 0; k < 6; k++) begin
			n = k % 3;
			axi_write((n == 2) ? `SFI_ADDR_IRQ_CTRL_B : `SFI_ADDR_IRQ_CTRL_A,
				32'((k / 3) << ((n == 2) ? 2 : n)), 2'h0);
			pulse(3'(1 << n));
			instr1(ops[n], s);
			`CHK("reqSkip", (k < 3), s)
			instr(10'h000);
			idle(3);
			rd_chk(`SFI_ADDR_FLAGS, {28'h0, powerDownFlag, flagsM}, 2'h0);
		end
		axi_write(`SFI_ADDR_IRQ_CTRL_A, 32'h0, 2'h0);
		axi_write(`SFI_ADDR_IRQ_CTRL_B, 32'h0, 2'h0);
		instr(`SFI_OP_EXT0_REQ);
		instr(`SFI_OP_EXT1_REQ);
		idle(3);
		rd_chk(`SFI_ADDR_FLAGS, 32'h6, 2'h0);
		for (k = 0; k < 8; k++) begin
			axi_write(k[2] ? `SFI_ADDR_EDGE_CTRL_B : `SFI_ADDR_EDGE_CTRL_A, {29'h0, k[0], 2'h0}, 2'h0);
			extIrqPinZero <= k[1];
			extIrqPinOne <= k[1];
			idle(4);
			instr1(k[2] ? `SFI_OP_EXT1_PIN : `SFI_OP_EXT0_PIN, s);
			`CHK("pinSkip", (k[1] == k[0]), s)
			instr(10'h000);
			idle(2);
		end
		for (k = 0; k < 2; k++) begin
			powerDownFlag <= k[0];
			idle(2);
			instr1(`SFI_OP_POWER_DOWN, s);
			`CHK("pdSkip", k[0], s)
			instr(10'h000);
			idle(2);
			rd_chk(`SFI_ADDR_FLAGS, {28'h0, k[0], flagsM}, 2'h0);
		end
		for (k = 0; k < 2; k++) begin
			rnd = $random(seed);
			axi_write(`SFI_ADDR_IRQ_CTRL_A, {28'h0, rnd[3:0]}, 2'h0);
			axi_write(`SFI_ADDR_IRQ_CTRL_B, {28'h0, rnd[7:4]}, 2'h0);
			axi_write(`SFI_ADDR_EDGE_CTRL_A, {28'h0, rnd[11:8]}, 2'h0);
			axi_write(`SFI_ADDR_EDGE_CTRL_B, {28'h0, rnd[15:12]}, 2'h0);
			extIrqPinZero <= rnd[16];
			extIrqPinOne <= rnd[17];
			idle(4);
			for (i = 0; i < 200; i++) begin
				rnd = $random(seed);
				instrIn <= '{valid: rnd[0], word: ops[rnd[10:8] % 7]};
				{conversionDoneSet, ext1RequestSet, ext0RequestSet} <= rnd[6:4] & rnd[14:12];
				powerDownFlag <= rnd[20];
				@(posedge sys_clk);
			end
			{conversionDoneSet, ext1RequestSet, ext0RequestSet} <= 3'h0;
			instr(10'h000);
			idle(3);
			rd_chk(`SFI_ADDR_FLAGS, {28'h0, powerDownFlag, flagsM}, 2'h0);
		end
		axi_write(`SFI_ADDR_MASK, 32'h0, 2'h0);
		idle(3);
		`CHK("irqMasked", 1'b0, irq_q)
		rd_chk(`SFI_ADDR_STATUS, {28'h0, statusM}, 2'h0);
		axi_write(`SFI_ADDR_MASK, 32'hf, 2'h0);
		idle(3);
		`CHK("irqRaised", (statusM != 4'h0), irq_q)
		axi_write(`SFI_ADDR_STATUS, 32'hf, 2'h0);
		idle(3);
		`CHK("irqCleared", 1'b0, irq_q)
		axi_write(`SFI_ADDR_MASK, 32'h2, 2'h0);
		powerDownFlag <= 1'b1;
		idle(2);
		instr1(`SFI_OP_POWER_DOWN, s);
		instr(10'h000);
		idle(3);
		`CHK("irqOtherBit", 1'b0, irq_q)
		rd_chk(`SFI_ADDR_STATUS, 32'h9, 2'h0);
		axi_write(`SFI_ADDR_MASK, 32'h1, 2'h0);
		idle(3);
		`CHK("irqSkip", 1'b1, irq_q)
		finish_test();
	end
endmodule // skip_on_flag_instructions_tb_top
